/* File: iemr_pkg.sv */
package iemr_pkg;
	localparam int REG_W = 16;
	localparam int ADDR_W = 4;
	// Register offsets on the plain register port
	localparam logic [ADDR_W-1:0] OFS_EN_LOW = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_EN_HIGH = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_REQ_LOW = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_REQ_HIGH = 4'h3;
	// Writable bit masks, unimplemented bits cleared
	localparam logic [REG_W-1:0] MASK_EN_LOW = 16'h7FFF;
	localparam logic [REG_W-1:0] MASK_EN_HIGH = 16'hFFDF;
	localparam logic [REG_W-1:0] RST_EN = 16'h0000;
	// Low group bit positions
	localparam int B_EXT_IRQ_A = 0;
	localparam int B_IN_CAPTURE_A = 1;
	localparam int B_OUT_COMPARE_A = 2;
	localparam int B_TIMER_A = 3;
	localparam int B_DMA_CH0_DONE = 4;
	localparam int B_IN_CAPTURE_B = 5;
	localparam int B_OUT_COMPARE_B = 6;
	localparam int B_TIMER_B = 7;
	localparam int B_TIMER_C = 8;
	localparam int B_SPI_A_ERROR = 9;
	localparam int B_SPI_A_EVENT = 10;
	localparam int B_UART_A_RX = 11;
	localparam int B_UART_A_TX = 12;
	localparam int B_ADC_CONV_DONE = 13;
	localparam int B_DMA_CH1_DONE = 14;
	// High group bit positions
	localparam int B_I2C_SLAVE_EVT = 0;
	localparam int B_I2C_MASTER_EVT = 1;
	localparam int B_COMPARATOR = 2;
	localparam int B_PIN_CHANGE = 3;
	localparam int B_EXT_IRQ_B = 4;
	localparam int B_IN_CAPTURE_G = 6;
	localparam int B_IN_CAPTURE_H = 7;
	localparam int B_DMA_CH2_DONE = 8;
	localparam int B_OUT_COMPARE_C = 9;
	localparam int B_OUT_COMPARE_D = 10;
	localparam int B_TIMER_D = 11;
	localparam int B_TIMER_E = 12;
	localparam int B_EXT_IRQ_C = 13;
	localparam int B_UART_B_RX = 14;
	localparam int B_UART_B_TX = 15;
endpackage

/* File: iemr_bus_if.sv */
interface iemr_bus_if;
	logic [iemr_pkg::REG_W-1:0] wdata;
	logic wr_low;
	logic wr_high;
	logic [iemr_pkg::REG_W-1:0] en_low;
	logic [iemr_pkg::REG_W-1:0] en_high;
	modport ctrl (output wdata, output wr_low, output wr_high, input en_low, input en_high);
	modport regs (input wdata, input wr_low, input wr_high, output en_low, output en_high);
endinterface

/* File: iemr_en_reg.sv */
module iemr_en_reg #(
	parameter int W = 16,
	parameter logic [W-1:0] MASK = '1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic we_i,
	input wire logic [W-1:0] wdata_i,
	output logic [W-1:0] q_o
);
	// Refuse a register the storage cannot hold
	if (W < 1)
	begin : g_bad_width
		$error("width must be positive");
	end
	logic [W-1:0] q_q;
	logic [W-1:0] q_d;
	// Masked bits never store, so they read zero forever
	assign q_d = we_i ? (wdata_i & MASK) : q_q;
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			q_q <= RST & MASK;
		else
			q_q <= q_d;
	end
	assign q_o = q_q;
endmodule

/* File: iemr_top.sv */
// Notes on behaviour
// - Enable one passes request, zero blocks it
// - Low bit 15, high bit 5 read zero
// - Low 14 DMA ch1, 13 ADC
// - Low 12 UART A tx, 11 rx
// - Low 10 SPI A event, 9 error
// - Low 8,7,3 timers C, B, A
// - Low 6 compare B, 2 compare A
// - Low 5 capture B, 1 capture A
// - Low 4 DMA ch0 done
// - Low 0 external interrupt A
// - High 15 UART B tx, 14 rx
// - High 13 ext C, 4 ext B
// - High 12 timer E, 11 timer D
// - High 10 compare D, 9 compare C
// - High 8 DMA ch2 done
// - High 7 capture H, 6 capture G
// - High 3 pin change
// - High 2 comparator, 1/0 I2C master/slave
module iemr_top (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RSTN_I,
	// Register port
	input wire logic [iemr_pkg::ADDR_W-1:0] ADDR_I,
	input wire logic [iemr_pkg::REG_W-1:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [iemr_pkg::REG_W-1:0] RDATA_O,
	// Source flags and gated requests
	input wire logic [iemr_pkg::REG_W-1:0] FLAG_LOW_I,
	input wire logic [iemr_pkg::REG_W-1:0] FLAG_HIGH_I,
	output logic [iemr_pkg::REG_W-1:0] REQ_LOW_O,
	output logic [iemr_pkg::REG_W-1:0] REQ_HIGH_O
);
	iemr_bus_if bus ();

	wire hit_low = ADDR_I == iemr_pkg::OFS_EN_LOW;
	wire hit_high = ADDR_I == iemr_pkg::OFS_EN_HIGH;
	wire hit_req_low = ADDR_I == iemr_pkg::OFS_REQ_LOW;
	wire hit_req_high = ADDR_I == iemr_pkg::OFS_REQ_HIGH;

	assign bus.wdata = WDATA_I;
	assign bus.wr_low = WR_I && hit_low;
	assign bus.wr_high = WR_I && hit_high;

	// Writes drop reserved bits inside the register
	iemr_en_reg #(
		.W(iemr_pkg::REG_W),
		.MASK(iemr_pkg::MASK_EN_LOW),
		.RST(iemr_pkg::RST_EN)
	) u_en_low (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.we_i(bus.wr_low),
		.wdata_i(bus.wdata),
		.q_o(bus.en_low)
	);

	iemr_en_reg #(
		.W(iemr_pkg::REG_W),
		.MASK(iemr_pkg::MASK_EN_HIGH),
		.RST(iemr_pkg::RST_EN)
	) u_en_high (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.we_i(bus.wr_high),
		.wdata_i(bus.wdata),
		.q_o(bus.en_high)
	);

	// Reserved bits must stay out of the writable masks
	if (iemr_pkg::MASK_EN_LOW[15] || iemr_pkg::MASK_EN_HIGH[5])
	begin : g_bad_mask
		$error("reserved enable bit is writable");
	end

	// Per source enables, low group
	wire ext_irq_a_en;
	wire in_capture_a_en;
	wire out_compare_a_en;
	wire timer_a_en;
	wire dma_ch0_done_en;
	wire in_capture_b_en;
	wire out_compare_b_en;
	wire timer_b_en;
	wire timer_c_en;
	wire spi_a_error_en;
	wire spi_a_event_en;
	wire uart_a_rx_en;
	wire uart_a_tx_en;
	wire adc_conv_done_en;
	wire dma_ch1_done_en;
	// Per source enables, high group
	wire i2c_slave_evt_en;
	wire i2c_master_evt_en;
	wire comparator_en;
	wire pin_change_en;
	wire ext_irq_b_en;
	wire in_capture_g_en;
	wire in_capture_h_en;
	wire dma_ch2_done_en;
	wire out_compare_c_en;
	wire out_compare_d_en;
	wire timer_d_en;
	wire timer_e_en;
	wire ext_irq_c_en;
	wire uart_b_rx_en;
	wire uart_b_tx_en;

	assign ext_irq_a_en = bus.en_low[iemr_pkg::B_EXT_IRQ_A];
	assign in_capture_a_en = bus.en_low[iemr_pkg::B_IN_CAPTURE_A];
	assign out_compare_a_en = bus.en_low[iemr_pkg::B_OUT_COMPARE_A];
	assign timer_a_en = bus.en_low[iemr_pkg::B_TIMER_A];
	assign dma_ch0_done_en = bus.en_low[iemr_pkg::B_DMA_CH0_DONE];
	assign in_capture_b_en = bus.en_low[iemr_pkg::B_IN_CAPTURE_B];
	assign out_compare_b_en = bus.en_low[iemr_pkg::B_OUT_COMPARE_B];
	assign timer_b_en = bus.en_low[iemr_pkg::B_TIMER_B];
	assign timer_c_en = bus.en_low[iemr_pkg::B_TIMER_C];
	assign spi_a_error_en = bus.en_low[iemr_pkg::B_SPI_A_ERROR];
	assign spi_a_event_en = bus.en_low[iemr_pkg::B_SPI_A_EVENT];
	assign uart_a_rx_en = bus.en_low[iemr_pkg::B_UART_A_RX];
	assign uart_a_tx_en = bus.en_low[iemr_pkg::B_UART_A_TX];
	assign adc_conv_done_en = bus.en_low[iemr_pkg::B_ADC_CONV_DONE];
	assign dma_ch1_done_en = bus.en_low[iemr_pkg::B_DMA_CH1_DONE];
	assign i2c_slave_evt_en = bus.en_high[iemr_pkg::B_I2C_SLAVE_EVT];
	assign i2c_master_evt_en = bus.en_high[iemr_pkg::B_I2C_MASTER_EVT];
	assign comparator_en = bus.en_high[iemr_pkg::B_COMPARATOR];
	assign pin_change_en = bus.en_high[iemr_pkg::B_PIN_CHANGE];
	assign ext_irq_b_en = bus.en_high[iemr_pkg::B_EXT_IRQ_B];
	assign in_capture_g_en = bus.en_high[iemr_pkg::B_IN_CAPTURE_G];
	assign in_capture_h_en = bus.en_high[iemr_pkg::B_IN_CAPTURE_H];
	assign dma_ch2_done_en = bus.en_high[iemr_pkg::B_DMA_CH2_DONE];
	assign out_compare_c_en = bus.en_high[iemr_pkg::B_OUT_COMPARE_C];
	assign out_compare_d_en = bus.en_high[iemr_pkg::B_OUT_COMPARE_D];
	assign timer_d_en = bus.en_high[iemr_pkg::B_TIMER_D];
	assign timer_e_en = bus.en_high[iemr_pkg::B_TIMER_E];
	assign ext_irq_c_en = bus.en_high[iemr_pkg::B_EXT_IRQ_C];
	assign uart_b_rx_en = bus.en_high[iemr_pkg::B_UART_B_RX];
	assign uart_b_tx_en = bus.en_high[iemr_pkg::B_UART_B_TX];

	// Source pending flags, taken as they arrive
	wire ext_irq_a_flag;
	wire in_capture_a_flag;
	wire out_compare_a_flag;
	wire timer_a_flag;
	wire dma_ch0_done_flag;
	wire in_capture_b_flag;
	wire out_compare_b_flag;
	wire timer_b_flag;
	wire timer_c_flag;
	wire spi_a_error_flag;
	wire spi_a_event_flag;
	wire uart_a_rx_flag;
	wire uart_a_tx_flag;
	wire adc_conv_done_flag;
	wire dma_ch1_done_flag;
	wire i2c_slave_evt_flag;
	wire i2c_master_evt_flag;
	wire comparator_flag;
	wire pin_change_flag;
	wire ext_irq_b_flag;
	wire in_capture_g_flag;
	wire in_capture_h_flag;
	wire dma_ch2_done_flag;
	wire out_compare_c_flag;
	wire out_compare_d_flag;
	wire timer_d_flag;
	wire timer_e_flag;
	wire ext_irq_c_flag;
	wire uart_b_rx_flag;
	wire uart_b_tx_flag;

	assign ext_irq_a_flag = FLAG_LOW_I[iemr_pkg::B_EXT_IRQ_A];
	assign in_capture_a_flag = FLAG_LOW_I[iemr_pkg::B_IN_CAPTURE_A];
	assign out_compare_a_flag = FLAG_LOW_I[iemr_pkg::B_OUT_COMPARE_A];
	assign timer_a_flag = FLAG_LOW_I[iemr_pkg::B_TIMER_A];
	assign dma_ch0_done_flag = FLAG_LOW_I[iemr_pkg::B_DMA_CH0_DONE];
	assign in_capture_b_flag = FLAG_LOW_I[iemr_pkg::B_IN_CAPTURE_B];
	assign out_compare_b_flag = FLAG_LOW_I[iemr_pkg::B_OUT_COMPARE_B];
	assign timer_b_flag = FLAG_LOW_I[iemr_pkg::B_TIMER_B];
	assign timer_c_flag = FLAG_LOW_I[iemr_pkg::B_TIMER_C];
	assign spi_a_error_flag = FLAG_LOW_I[iemr_pkg::B_SPI_A_ERROR];
	assign spi_a_event_flag = FLAG_LOW_I[iemr_pkg::B_SPI_A_EVENT];
	assign uart_a_rx_flag = FLAG_LOW_I[iemr_pkg::B_UART_A_RX];
	assign uart_a_tx_flag = FLAG_LOW_I[iemr_pkg::B_UART_A_TX];
	assign adc_conv_done_flag = FLAG_LOW_I[iemr_pkg::B_ADC_CONV_DONE];
	assign dma_ch1_done_flag = FLAG_LOW_I[iemr_pkg::B_DMA_CH1_DONE];
	assign i2c_slave_evt_flag = FLAG_HIGH_I[iemr_pkg::B_I2C_SLAVE_EVT];
	assign i2c_master_evt_flag = FLAG_HIGH_I[iemr_pkg::B_I2C_MASTER_EVT];
	assign comparator_flag = FLAG_HIGH_I[iemr_pkg::B_COMPARATOR];
	assign pin_change_flag = FLAG_HIGH_I[iemr_pkg::B_PIN_CHANGE];
	assign ext_irq_b_flag = FLAG_HIGH_I[iemr_pkg::B_EXT_IRQ_B];
	assign in_capture_g_flag = FLAG_HIGH_I[iemr_pkg::B_IN_CAPTURE_G];
	assign in_capture_h_flag = FLAG_HIGH_I[iemr_pkg::B_IN_CAPTURE_H];
	assign dma_ch2_done_flag = FLAG_HIGH_I[iemr_pkg::B_DMA_CH2_DONE];
	assign out_compare_c_flag = FLAG_HIGH_I[iemr_pkg::B_OUT_COMPARE_C];
	assign out_compare_d_flag = FLAG_HIGH_I[iemr_pkg::B_OUT_COMPARE_D];
	assign timer_d_flag = FLAG_HIGH_I[iemr_pkg::B_TIMER_D];
	assign timer_e_flag = FLAG_HIGH_I[iemr_pkg::B_TIMER_E];
	assign ext_irq_c_flag = FLAG_HIGH_I[iemr_pkg::B_EXT_IRQ_C];
	assign uart_b_rx_flag = FLAG_HIGH_I[iemr_pkg::B_UART_B_RX];
	assign uart_b_tx_flag = FLAG_HIGH_I[iemr_pkg::B_UART_B_TX];

	// Gating is combinational so a new flag reaches the CPU without delay;
	// flags are never touched here, disabling only hides them.
	wire ext_irq_a_req;
	wire in_capture_a_req;
	wire out_compare_a_req;
	wire timer_a_req;
	wire dma_ch0_done_req;
	wire in_capture_b_req;
	wire out_compare_b_req;
	wire timer_b_req;
	wire timer_c_req;
	wire spi_a_error_req;
	wire spi_a_event_req;
	wire uart_a_rx_req;
	wire uart_a_tx_req;
	wire adc_conv_done_req;
	wire dma_ch1_done_req;
	wire i2c_slave_evt_req;
	wire i2c_master_evt_req;
	wire comparator_req;
	wire pin_change_req;
	wire ext_irq_b_req;
	wire in_capture_g_req;
	wire in_capture_h_req;
	wire dma_ch2_done_req;
	wire out_compare_c_req;
	wire out_compare_d_req;
	wire timer_d_req;
	wire timer_e_req;
	wire ext_irq_c_req;
	wire uart_b_rx_req;
	wire uart_b_tx_req;

	assign ext_irq_a_req = ext_irq_a_flag & ext_irq_a_en;
	assign in_capture_a_req = in_capture_a_flag & in_capture_a_en;
	assign out_compare_a_req = out_compare_a_flag & out_compare_a_en;
	assign timer_a_req = timer_a_flag & timer_a_en;
	assign dma_ch0_done_req = dma_ch0_done_flag & dma_ch0_done_en;
	assign in_capture_b_req = in_capture_b_flag & in_capture_b_en;
	assign out_compare_b_req = out_compare_b_flag & out_compare_b_en;
	assign timer_b_req = timer_b_flag & timer_b_en;
	assign timer_c_req = timer_c_flag & timer_c_en;
	assign spi_a_error_req = spi_a_error_flag & spi_a_error_en;
	assign spi_a_event_req = spi_a_event_flag & spi_a_event_en;
	assign uart_a_rx_req = uart_a_rx_flag & uart_a_rx_en;
	assign uart_a_tx_req = uart_a_tx_flag & uart_a_tx_en;
	assign adc_conv_done_req = adc_conv_done_flag & adc_conv_done_en;
	assign dma_ch1_done_req = dma_ch1_done_flag & dma_ch1_done_en;
	assign i2c_slave_evt_req = i2c_slave_evt_flag & i2c_slave_evt_en;
	assign i2c_master_evt_req = i2c_master_evt_flag & i2c_master_evt_en;
	assign comparator_req = comparator_flag & comparator_en;
	assign pin_change_req = pin_change_flag & pin_change_en;
	assign ext_irq_b_req = ext_irq_b_flag & ext_irq_b_en;
	assign in_capture_g_req = in_capture_g_flag & in_capture_g_en;
	assign in_capture_h_req = in_capture_h_flag & in_capture_h_en;
	assign dma_ch2_done_req = dma_ch2_done_flag & dma_ch2_done_en;
	assign out_compare_c_req = out_compare_c_flag & out_compare_c_en;
	assign out_compare_d_req = out_compare_d_flag & out_compare_d_en;
	assign timer_d_req = timer_d_flag & timer_d_en;
	assign timer_e_req = timer_e_flag & timer_e_en;
	assign ext_irq_c_req = ext_irq_c_flag & ext_irq_c_en;
	assign uart_b_rx_req = uart_b_rx_flag & uart_b_rx_en;
	assign uart_b_tx_req = uart_b_tx_flag & uart_b_tx_en;

	// Reserved positions are tied low, never left floating
	wire [iemr_pkg::REG_W-1:0] gate_low;
	wire [iemr_pkg::REG_W-1:0] gate_high;
	assign gate_low[15] = 1'b0;
	assign gate_low[iemr_pkg::B_DMA_CH1_DONE] = dma_ch1_done_req;
	assign gate_low[iemr_pkg::B_ADC_CONV_DONE] = adc_conv_done_req;
	assign gate_low[iemr_pkg::B_UART_A_TX] = uart_a_tx_req;
	assign gate_low[iemr_pkg::B_UART_A_RX] = uart_a_rx_req;
	assign gate_low[iemr_pkg::B_SPI_A_EVENT] = spi_a_event_req;
	assign gate_low[iemr_pkg::B_SPI_A_ERROR] = spi_a_error_req;
	assign gate_low[iemr_pkg::B_TIMER_C] = timer_c_req;
	assign gate_low[iemr_pkg::B_TIMER_B] = timer_b_req;
	assign gate_low[iemr_pkg::B_OUT_COMPARE_B] = out_compare_b_req;
	assign gate_low[iemr_pkg::B_IN_CAPTURE_B] = in_capture_b_req;
	assign gate_low[iemr_pkg::B_DMA_CH0_DONE] = dma_ch0_done_req;
	assign gate_low[iemr_pkg::B_TIMER_A] = timer_a_req;
	assign gate_low[iemr_pkg::B_OUT_COMPARE_A] = out_compare_a_req;
	assign gate_low[iemr_pkg::B_IN_CAPTURE_A] = in_capture_a_req;
	assign gate_low[iemr_pkg::B_EXT_IRQ_A] = ext_irq_a_req;
	assign gate_high[iemr_pkg::B_UART_B_TX] = uart_b_tx_req;
	assign gate_high[iemr_pkg::B_UART_B_RX] = uart_b_rx_req;
	assign gate_high[iemr_pkg::B_EXT_IRQ_C] = ext_irq_c_req;
	assign gate_high[iemr_pkg::B_TIMER_E] = timer_e_req;
	assign gate_high[iemr_pkg::B_TIMER_D] = timer_d_req;
	assign gate_high[iemr_pkg::B_OUT_COMPARE_D] = out_compare_d_req;
	assign gate_high[iemr_pkg::B_OUT_COMPARE_C] = out_compare_c_req;
	assign gate_high[iemr_pkg::B_DMA_CH2_DONE] = dma_ch2_done_req;
	assign gate_high[iemr_pkg::B_IN_CAPTURE_H] = in_capture_h_req;
	assign gate_high[iemr_pkg::B_IN_CAPTURE_G] = in_capture_g_req;
	assign gate_high[5] = 1'b0;
	assign gate_high[iemr_pkg::B_EXT_IRQ_B] = ext_irq_b_req;
	assign gate_high[iemr_pkg::B_PIN_CHANGE] = pin_change_req;
	assign gate_high[iemr_pkg::B_COMPARATOR] = comparator_req;
	assign gate_high[iemr_pkg::B_I2C_MASTER_EVT] = i2c_master_evt_req;
	assign gate_high[iemr_pkg::B_I2C_SLAVE_EVT] = i2c_slave_evt_req;

	assign REQ_LOW_O = gate_low;
	assign REQ_HIGH_O = gate_high;

	// Readback is rebuilt from the named enables, reserved bits read zero
	wire [iemr_pkg::REG_W-1:0] rb_low;
	wire [iemr_pkg::REG_W-1:0] rb_high;
	assign rb_low[15] = 1'b0;
	assign rb_low[iemr_pkg::B_DMA_CH1_DONE] = dma_ch1_done_en;
	assign rb_low[iemr_pkg::B_ADC_CONV_DONE] = adc_conv_done_en;
	assign rb_low[iemr_pkg::B_UART_A_TX] = uart_a_tx_en;
	assign rb_low[iemr_pkg::B_UART_A_RX] = uart_a_rx_en;
	assign rb_low[iemr_pkg::B_SPI_A_EVENT] = spi_a_event_en;
	assign rb_low[iemr_pkg::B_SPI_A_ERROR] = spi_a_error_en;
	assign rb_low[iemr_pkg::B_TIMER_C] = timer_c_en;
	assign rb_low[iemr_pkg::B_TIMER_B] = timer_b_en;
	assign rb_low[iemr_pkg::B_OUT_COMPARE_B] = out_compare_b_en;
	assign rb_low[iemr_pkg::B_IN_CAPTURE_B] = in_capture_b_en;
	assign rb_low[iemr_pkg::B_DMA_CH0_DONE] = dma_ch0_done_en;
	assign rb_low[iemr_pkg::B_TIMER_A] = timer_a_en;
	assign rb_low[iemr_pkg::B_OUT_COMPARE_A] = out_compare_a_en;
	assign rb_low[iemr_pkg::B_IN_CAPTURE_A] = in_capture_a_en;
	assign rb_low[iemr_pkg::B_EXT_IRQ_A] = ext_irq_a_en;
	assign rb_high[iemr_pkg::B_UART_B_TX] = uart_b_tx_en;
	assign rb_high[iemr_pkg::B_UART_B_RX] = uart_b_rx_en;
	assign rb_high[iemr_pkg::B_EXT_IRQ_C] = ext_irq_c_en;
	assign rb_high[iemr_pkg::B_TIMER_E] = timer_e_en;
	assign rb_high[iemr_pkg::B_TIMER_D] = timer_d_en;
	assign rb_high[iemr_pkg::B_OUT_COMPARE_D] = out_compare_d_en;
	assign rb_high[iemr_pkg::B_OUT_COMPARE_C] = out_compare_c_en;
	assign rb_high[iemr_pkg::B_DMA_CH2_DONE] = dma_ch2_done_en;
	assign rb_high[iemr_pkg::B_IN_CAPTURE_H] = in_capture_h_en;
	assign rb_high[iemr_pkg::B_IN_CAPTURE_G] = in_capture_g_en;
	assign rb_high[5] = 1'b0;
	assign rb_high[iemr_pkg::B_EXT_IRQ_B] = ext_irq_b_en;
	assign rb_high[iemr_pkg::B_PIN_CHANGE] = pin_change_en;
	assign rb_high[iemr_pkg::B_COMPARATOR] = comparator_en;
	assign rb_high[iemr_pkg::B_I2C_MASTER_EVT] = i2c_master_evt_en;
	assign rb_high[iemr_pkg::B_I2C_SLAVE_EVT] = i2c_slave_evt_en;

	wire [iemr_pkg::REG_W-1:0] rd_mux =
		hit_low ? rb_low :
		hit_high ? rb_high :
		hit_req_low ? gate_low :
		hit_req_high ? gate_high : 16'h0000;

	logic [iemr_pkg::REG_W-1:0] rdata_q;
	always_ff @(posedge CLK_I)
	begin
		if (!RSTN_I)
			rdata_q <= 16'h0000;
		else if (RD_I)
			rdata_q <= rd_mux;
		else
			rdata_q <= 16'h0000;
	end
	assign RDATA_O = rdata_q;
endmodule

/* File: iemr_src_model.sv */
module iemr_src_model (
	input logic clk_i,
	input logic [31:0] set_i,
	output logic [31:0] flag_o = 0
);
	// Flags move only after an edge, as real source flops would
	always @(posedge clk_i) flag_o <= set_i;
endmodule

/* File: iemr_top_assertions.sv */
module iemr_top_assertions (
	input logic CLK_I, RSTN_I, WR_I, RD_I,
	input logic [3:0] ADDR_I,
	input logic [15:0] WDATA_I, RDATA_O, FLAG_LOW_I, FLAG_HIGH_I, REQ_LOW_O, REQ_HIGH_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	sequence s_wl; WR_I && ADDR_I == iemr_pkg::OFS_EN_LOW; endsequence
	sequence s_wh; WR_I && ADDR_I == iemr_pkg::OFS_EN_HIGH; endsequence
	property p_rs; $rose(RSTN_I) |-> !(REQ_LOW_O | REQ_HIGH_O); endproperty
	a_rs: assert property (p_rs) else $error("req after reset");
	property p_gt; !(REQ_LOW_O & ~FLAG_LOW_I | REQ_HIGH_O & ~FLAG_HIGH_I); endproperty
	a_gt: assert property (p_gt) else $error("req without flag");
	property p_un; !REQ_LOW_O[15] && !REQ_HIGH_O[5]; endproperty
	a_un: assert property (p_un) else $error("unused bit");
	property p_um; RD_I && ADDR_I > 3 |=> !RDATA_O; endproperty
	a_um: assert property (p_um) else $error("unmapped read");
	property p_ql; s_wl |=> REQ_LOW_O == ($past(WDATA_I) & iemr_pkg::MASK_EN_LOW & FLAG_LOW_I);
	endproperty
	a_ql: assert property (p_ql) else $error("low gate");
	property p_qh; s_wh |=> REQ_HIGH_O == ($past(WDATA_I) & iemr_pkg::MASK_EN_HIGH & FLAG_HIGH_I);
	endproperty
	a_qh: assert property (p_qh) else $error("high gate");
	property p_rl; s_wl ##1 RD_I && ADDR_I == iemr_pkg::OFS_EN_LOW
		|=> RDATA_O == ($past(WDATA_I, 2) & iemr_pkg::MASK_EN_LOW);
	endproperty
	a_rl: assert property (p_rl) else $error("low readback");
	property p_rh; s_wh ##1 RD_I && ADDR_I == iemr_pkg::OFS_EN_HIGH
		|=> RDATA_O == ($past(WDATA_I, 2) & iemr_pkg::MASK_EN_HIGH);
	endproperty
	a_rh: assert property (p_rh) else $error("high readback");
endmodule
bind iemr_top iemr_top_assertions chk (.*);

/* File: iemr_top_test.sv */
module iemr_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rstn = 0, wr = 0, rd = 0, rd_q;
	logic [3:0] addr = 0;
	logic [15:0] wdata = 0, rdata, rql, rqh, expq[$];
	logic [31:0] en, fl, set = 0, seed = 32'h0000_cd5f;
	wire [31:0] q = en & fl;
	int n_mismatch = 0, checks_done = 0;
	always #2 clk = ~clk;
	iemr_src_model src (.clk_i(clk), .set_i(set), .flag_o(fl));
	iemr_top dut (.CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
		.RD_I(rd), .RDATA_O(rdata), .FLAG_LOW_I(fl[15:0]), .FLAG_HIGH_I(fl[31:16]),
		.REQ_LOW_O(rql), .REQ_HIGH_O(rqh));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task chk(input logic ok);
		checks_done++;
		if (!ok)
			n_mismatch++;
		if (!ok)
			$display("MISMATCH %0t bad output", $time);
	endtask
	task summarize;
		$display("%0d mismatches, %0d checks", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Mirror the bus at the sampling edge so a read right after a write sees it
	always @(posedge clk)
	begin
		rd_q <= rd;
		if (!rstn)
			en <= 0;
		else if (wr && addr < 2)
			en[addr[0]*16 +: 16] <= wdata & (addr[0] ? iemr_pkg::MASK_EN_HIGH : iemr_pkg::MASK_EN_LOW);
		if (rd)
			expq.push_back(addr < 2 ? en[addr[0]*16 +: 16] : addr < 4 ? q[addr[0]*16 +: 16] : 0);
	end
	always @(negedge clk)
		if (rstn)
		begin
			chk({rqh, rql} === q);
			if (rd_q)
				chk(rdata === expq.pop_front());
		end
	initial
	begin
		repeat (2)
		begin
			@(posedge clk);
			{wr, rd} <= 0;
			@(posedge clk);
			rstn <= 0;
			repeat (5) @(posedge clk);
			rstn <= 1;
			repeat (300)
			begin
				seed = xs(seed);
				@(posedge clk);
				{wr, rd, wdata, set} <= {seed[31], !seed[31], seed[30:15], xs(seed)};
				addr <= seed[4] ? seed[3:0] : {3'b000, seed[0]};
			end
		end
		@(posedge clk);
		{wr, rd} <= 0;
		@(posedge clk);
		summarize;
	end
	initial
	begin
		#20000;
		n_mismatch++;
		summarize;
	end
endmodule
